// *** hdl/dspm_map.vh ***
`ifndef DSPM_MAP_VH
`define DSPM_MAP_VH
// Register byte offsets.
`define DSPM_CTRL_OFF 8'h00
`define DSPM_CFG_OFF 8'h04
`define DSPM_STAT_OFF 8'h08
`define DSPM_GNSS_OFF 8'h0C
`define DSPM_SLEEP_OFF 8'h10
`define DSPM_PIN_OFF 8'h14
`define DSPM_ELAPSED_OFF 8'h18
// Sleep depth encoding.
`define DSPM_DEPTH_NONE 2'h0
`define DSPM_DEPTH_FULL 2'h1
`define DSPM_DEPTH_PART 2'h2
`define DSPM_DEPTH_DEEP 2'h3
`define DSPM_DEPTH_RST 2'h1
// CTRL fields.
`define DSPM_CTRL_SLEEP_BIT 0
`define DSPM_CTRL_SOFTRST_BIT 1
`define DSPM_CTRL_RADIO_BIT 2
`define DSPM_CTRL_LTE_BIT 3
// CFG fields.
`define DSPM_CFG_DEPTH_LSB 0
`define DSPM_CFG_RET_LSB 4
`define DSPM_CFG_RET_W 5
`define DSPM_CFG_RET_RST 5'h01
// GNSS command fields.
`define DSPM_GNSS_START 2'h1
`define DSPM_GNSS_STOP 2'h2
// Answer codes.
`define DSPM_RESP_OK 2'h0
`define DSPM_RESP_ERR 2'h2
`define DSPM_AXI_OKAY 2'h0
`define DSPM_AXI_SLVERR 2'h2
// Timing.
`define DSPM_CLK_HZ 25000000
`define DSPM_GUARD_MIN 30
`define DSPM_TICK_SEC 1
`define DSPM_TICK_CYC (`DSPM_CLK_HZ * `DSPM_TICK_SEC)
`endif

// *** hdl/dspm_tick.v ***
`timescale 1ns/1ps
`include "dspm_map.vh"
// ==========================================================
// Seconds prescaler and saturating elapsed-seconds counter.
module dspm_tick #(
  parameter TICK_CYC = `DSPM_TICK_CYC,
  parameter CW = 32
) (
  aclk,
  aresetn,
  ce,
  clear,
  elapsed
);
  input wire aclk;
  input wire aresetn;
  input wire ce;
  input wire clear;
  output reg [CW-1:0] elapsed;
  reg [31:0] pre_q;
  wire tick;
  assign tick = (pre_q == TICK_CYC - 1);
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 32'h0000_0000;
      elapsed <= {CW{1'b1}};
    end else if (ce) begin
      if (clear) begin
        pre_q <= 32'h0000_0000;
        elapsed <= {CW{1'b0}};
      end else begin
        pre_q <= tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
        if (tick && (elapsed != {CW{1'b1}}))
          elapsed <= elapsed + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // dspm_tick

// *** hdl/dspm_ctrl.v ***
`timescale 1ns/1ps
`include "dspm_map.vh"
module dspm_ctrl #(
  parameter TICK_CYC = `DSPM_TICK_CYC,
  parameter GUARD_SEC = `DSPM_GUARD_MIN * 60,
  parameter NPIN = 8,
  parameter [7:0] DEF_PULL_UP = 8'hA5
) (
  aclk,
  aresetn,
  ce,
  awaddr,
  awvalid,
  awready,
  wdata,
  wstrb,
  wvalid,
  wready,
  bresp,
  bvalid,
  bready,
  araddr,
  arvalid,
  arready,
  rdata,
  rresp,
  rvalid,
  rready,
  wake_pin,
  reset_pin_n,
  dig_wake_in,
  pwr_good,
  logic_power_en,
  io_supply_en,
  sram_retain,
  ret_blocks_64k,
  out_latch,
  pull_en,
  pull_up,
  boot_req,
  gnss_active
);
  input wire aclk;
  input wire aresetn;
  input wire ce;
  input wire [7:0] awaddr;
  input wire awvalid;
  output wire awready;
  input wire [31:0] wdata;
  input wire [3:0] wstrb;
  input wire wvalid;
  output wire wready;
  output reg [1:0] bresp;
  output reg bvalid;
  input wire bready;
  input wire [7:0] araddr;
  input wire arvalid;
  output wire arready;
  output reg [31:0] rdata;
  output reg [1:0] rresp;
  output reg rvalid;
  input wire rready;
  input wire wake_pin;
  input wire reset_pin_n;
  input wire dig_wake_in;
  input wire pwr_good;
  output reg logic_power_en;
  output reg io_supply_en;
  output reg sram_retain;
  output reg [4:0] ret_blocks_64k;
  output reg out_latch;
  output reg [NPIN-1:0] pull_en;
  output reg [NPIN-1:0] pull_up;
  output reg boot_req;
  output reg gnss_active;

  // ==========================================================
  // States.
  localparam [4:0] ST_RUN = 5'b00001;
  localparam [4:0] ST_FULL = 5'b00010;
  localparam [4:0] ST_PART = 5'b00100;
  localparam [4:0] ST_DEEP = 5'b01000;
  localparam [4:0] ST_BOOT = 5'b10000;

  reg [4:0] st_q;
  reg [1:0] max_depth_q;
  reg [4:0] ret_cfg_q;
  reg [31:0] sleep_sec_q;
  reg [NPIN-1:0] cfg_pull_en_q;
  reg [NPIN-1:0] cfg_pull_up_q;
  reg radio_on_q;
  reg lte_active_q;
  reg [1:0] gnss_resp_q;
  reg [1:0] last_depth_q;
  reg deep_seen_q;
  reg guard_hit_q;
  reg gnss_killed_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire [31:0] elapsed;
  reg [1:0] depth_d;
  reg guard_d;

  // ==========================================================
  // Seconds since the last deepest-state entry.
  wire sleep_go;
  wire deep_entry;
  assign deep_entry = ce && (st_q == ST_RUN) && sleep_go && (depth_d == `DSPM_DEPTH_DEEP);

  dspm_tick #(
    .TICK_CYC(TICK_CYC),
    .CW(32)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .clear(deep_entry),
    .elapsed(elapsed)
  );

  // ==========================================================
  // AXI4-Lite write path: address and data taken in either order.
  wire aw_have;
  wire w_have;
  wire wr_fire;
  wire [7:0] wa;
  wire [31:0] wd;
  wire [3:0] ws;
  // Ready stays low while the clock enable is low, so no beat is lost in a frozen cycle.
  assign awready = ce && !aw_hold_q && !bvalid;
  assign wready = ce && !w_hold_q && !bvalid;
  assign aw_have = aw_hold_q || awvalid;
  assign w_have = w_hold_q || wvalid;
  assign wr_fire = ce && aw_have && w_have && !bvalid;
  assign wa = aw_hold_q ? awaddr_q : awaddr;
  assign wd = w_hold_q ? wdata_q : wdata;
  assign ws = w_hold_q ? wstrb_q : wstrb;
  wire wr_ctrl;
  wire wr_gnss;
  wire wr_ok;
  assign wr_ctrl = wr_fire && (wa == `DSPM_CTRL_OFF) && ws[0];
  assign wr_gnss = wr_fire && (wa == `DSPM_GNSS_OFF) && ws[0];
  assign wr_ok = (wa == `DSPM_CTRL_OFF) || (wa == `DSPM_CFG_OFF) || (wa == `DSPM_GNSS_OFF) ||
                 (wa == `DSPM_SLEEP_OFF) || (wa == `DSPM_PIN_OFF);
  assign sleep_go = wr_ctrl && wd[`DSPM_CTRL_SLEEP_BIT] && !radio_on_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `DSPM_AXI_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `DSPM_AXI_OKAY : `DSPM_AXI_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Configuration registers.
  always @(posedge aclk) begin
    if (!aresetn) begin
      max_depth_q <= `DSPM_DEPTH_RST;
      ret_cfg_q <= `DSPM_CFG_RET_RST;
      sleep_sec_q <= 32'h0000_0000;
      cfg_pull_en_q <= {NPIN{1'b0}};
      cfg_pull_up_q <= {NPIN{1'b0}};
      radio_on_q <= 1'b1;
      lte_active_q <= 1'b0;
      gnss_active <= 1'b0;
      gnss_resp_q <= `DSPM_RESP_OK;
      gnss_killed_q <= 1'b0;
    end else if (ce) begin
      if (wr_fire && (wa == `DSPM_CFG_OFF) && ws[0]) begin
        max_depth_q <= wd[`DSPM_CFG_DEPTH_LSB +: 2];
        ret_cfg_q <= wd[`DSPM_CFG_RET_LSB +: `DSPM_CFG_RET_W];
      end
      if (wr_fire && (wa == `DSPM_SLEEP_OFF))
        sleep_sec_q <= wd;
      if (wr_fire && (wa == `DSPM_PIN_OFF)) begin
        cfg_pull_en_q <= wd[NPIN-1:0];
        cfg_pull_up_q <= wd[8 +: NPIN];
      end
      if (wr_ctrl) begin
        radio_on_q <= wd[`DSPM_CTRL_RADIO_BIT];
        lte_active_q <= wd[`DSPM_CTRL_LTE_BIT];
      end
      if (lte_active_q && gnss_active) begin
        gnss_active <= 1'b0;
        gnss_killed_q <= 1'b1;
      end
      if (wr_gnss) begin
        if (lte_active_q) begin
          gnss_resp_q <= `DSPM_RESP_ERR;
        end else begin
          gnss_resp_q <= `DSPM_RESP_OK;
          if (wd[1:0] == `DSPM_GNSS_START) begin
            gnss_active <= 1'b1;
            gnss_killed_q <= 1'b0;
          end else if (wd[1:0] == `DSPM_GNSS_STOP) begin
            gnss_active <= 1'b0;
          end
        end
      end
      if (st_q != ST_RUN)
        gnss_active <= 1'b0;
    end
  end

  // ==========================================================
  // Depth choice with flash-wear guard.
  always @* begin
    guard_d = deep_seen_q && (elapsed < GUARD_SEC);
    if (sleep_sec_q < GUARD_SEC)
      guard_d = 1'b1;
    depth_d = max_depth_q;
    if (max_depth_q == `DSPM_DEPTH_DEEP && guard_d)
      depth_d = `DSPM_DEPTH_PART;
    if (max_depth_q == `DSPM_DEPTH_NONE)
      depth_d = `DSPM_DEPTH_FULL;
  end

  // ==========================================================
  // Sleep sequencer.
  wire wake_ev;
  assign wake_ev = wake_pin || !reset_pin_n || !pwr_good;

  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_RUN;
      last_depth_q <= `DSPM_DEPTH_NONE;
      deep_seen_q <= 1'b0;
      guard_hit_q <= 1'b0;
      boot_req <= 1'b0;
    end else if (ce) begin
      boot_req <= 1'b0;
      case (st_q)
        ST_RUN: begin
          if (sleep_go) begin
            last_depth_q <= depth_d;
            guard_hit_q <= (max_depth_q == `DSPM_DEPTH_DEEP) && guard_d;
            if (depth_d == `DSPM_DEPTH_DEEP) begin
              st_q <= ST_DEEP;
              deep_seen_q <= 1'b1;
            end else if (depth_d == `DSPM_DEPTH_PART) begin
              st_q <= ST_PART;
            end else begin
              st_q <= ST_FULL;
            end
          end
        end
        ST_FULL: begin
          if (wake_ev || dig_wake_in)
            st_q <= ST_BOOT;
        end
        ST_PART, ST_DEEP: begin
          if (wake_ev)
            st_q <= ST_BOOT;
        end
        ST_BOOT: begin
          boot_req <= 1'b1;
          st_q <= ST_RUN;
        end
        default: st_q <= ST_RUN;
      endcase
    end
  end

  // ==========================================================
  // Power, retention and pad controls.
  always @(posedge aclk) begin
    if (!aresetn) begin
      logic_power_en <= 1'b1;
      io_supply_en <= 1'b1;
      sram_retain <= 1'b0;
      ret_blocks_64k <= 5'h00;
      out_latch <= 1'b0;
      pull_en <= {NPIN{1'b1}};
      pull_up <= DEF_PULL_UP[NPIN-1:0];
    end else if (ce) begin
      logic_power_en <= (st_q == ST_RUN) || (st_q == ST_BOOT);
      io_supply_en <= !((st_q == ST_DEEP) || (st_q == ST_PART));
      sram_retain <= (st_q == ST_FULL);
      ret_blocks_64k <= (st_q == ST_PART) ? ret_cfg_q : 5'h00;
      out_latch <= (st_q == ST_FULL);
      if (st_q == ST_DEEP || st_q == ST_PART) begin
        pull_en <= {NPIN{1'b0}};
      end else if (st_q == ST_FULL) begin
        pull_en <= cfg_pull_en_q;
        pull_up <= cfg_pull_up_q;
      end else if (st_q == ST_BOOT && last_depth_q == `DSPM_DEPTH_DEEP) begin
        pull_en <= {NPIN{1'b1}};
        pull_up <= DEF_PULL_UP[NPIN-1:0];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path.
  assign arready = ce && !rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `DSPM_AXI_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= `DSPM_AXI_OKAY;
        case (araddr)
          `DSPM_CTRL_OFF: rdata <= {28'h000_0000, lte_active_q, radio_on_q, 2'b00};
          `DSPM_CFG_OFF: rdata <= {23'h00_0000, ret_cfg_q, 2'b00, max_depth_q};
          `DSPM_STAT_OFF: rdata <= {20'h0_0000, gnss_killed_q, guard_hit_q, deep_seen_q,
                                    gnss_active, last_depth_q, 1'b0, st_q};
          `DSPM_GNSS_OFF: rdata <= {28'h000_0000, lte_active_q, gnss_active, gnss_resp_q};
          `DSPM_SLEEP_OFF: rdata <= sleep_sec_q;
          `DSPM_PIN_OFF: rdata <= {16'h0000, cfg_pull_up_q, cfg_pull_en_q};
          `DSPM_ELAPSED_OFF: rdata <= elapsed;
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `DSPM_AXI_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // dspm_ctrl

// *** tb/dspm_ctrl_asserts.sv ***
`timescale 1ns/1ps
// ==========================================================
// Port-level checks of the sleep controller.
module dspm_ctrl_asserts #(
  parameter NPIN = 8
) (
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input logic bvalid,
  input logic bready,
  input logic [1:0] bresp,
  input logic arready,
  input logic rvalid,
  input logic rready,
  input logic [31:0] rdata,
  input logic [1:0] rresp,
  input logic wake_pin,
  input logic reset_pin_n,
  input logic pwr_good,
  input logic logic_power_en,
  input logic io_supply_en,
  input logic sram_retain,
  input logic [4:0] ret_blocks_64k,
  input logic out_latch,
  input logic [NPIN-1:0] pull_en,
  input logic boot_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rst_values_a: assert property (disable iff (1'b0) !aresetn && ce |=> logic_power_en
    && io_supply_en && !bvalid && !rvalid && !boot_req && pull_en == {NPIN{1'b1}})
    else $error("reset values wrong");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid
    && $stable({rdata, rresp})) else $error("read answer dropped early");
  read_ready_a: assert property (arready == (ce && !rvalid))
    else $error("read ready wrong");
  full_keep_a: assert property (sram_retain |-> out_latch && io_supply_en
    && ret_blocks_64k == 5'h00) else $error("full retention outputs wrong");
  supply_off_a: assert property (!io_supply_en |-> !out_latch
    && !sram_retain && pull_en == {NPIN{1'b0}}) else $error("state kept with supply off");
  part_blocks_a: assert property (ret_blocks_64k != 5'h00 |-> !io_supply_en)
    else $error("retention blocks outside partial state");
  boot_pulse_a: assert property (boot_req |=> !boot_req)
    else $error("boot request longer than one cycle");
  wake_boot_a: assert property (ce && (!io_supply_en || sram_retain)
    && (wake_pin || !reset_pin_n || !pwr_good) |-> ##[1:4] boot_req)
    else $error("no boot after wake");
  cover property (sram_retain);
  cover property (ret_blocks_64k != 5'h00);
  cover property (!io_supply_en && ret_blocks_64k == 5'h00);
  cover property (boot_req);
endmodule // dspm_ctrl_asserts

bind dspm_ctrl dspm_ctrl_asserts #(.NPIN(NPIN)) u_dspm_ctrl_asserts (.aclk(aclk),
  .aresetn(aresetn), .ce(ce), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
  .wake_pin(wake_pin), .reset_pin_n(reset_pin_n), .pwr_good(pwr_good),
  .logic_power_en(logic_power_en), .io_supply_en(io_supply_en), .sram_retain(sram_retain),
  .ret_blocks_64k(ret_blocks_64k), .out_latch(out_latch), .pull_en(pull_en),
  .boot_req(boot_req));

// *** tb/dspm_host_pins.sv ***
`timescale 1ns/1ps
// ==========================================================
// Host side of the wake lines; nothing else is driven while asleep.
module dspm_host_pins (
  input logic aclk,
  input logic go,
  input logic [1:0] kind,
  output logic wake_pin = 1'b0,
  output logic reset_pin_n = 1'b1,
  output logic pwr_good = 1'b1,
  output logic dig_wake_in = 1'b0
);
  always @(posedge aclk) begin
    wake_pin <= go && kind == 2'h0;
    reset_pin_n <= !(go && kind == 2'h1);
    pwr_good <= !(go && kind == 2'h2);
    dig_wake_in <= go && kind == 2'h3;
  end
endmodule // dspm_host_pins

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "dspm_map.vh"
// ==========================================================
// Random and corner-case sleep, wake and GNSS traffic.
module testbench;
  localparam TICK = 20;
  localparam GUARD = 5;
  logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rnd = 32'd86797, rv;
  logic [1:0] kind = 2'h0, r2, d;
  logic [4:0] ret;
  logic [15:0] pin;
  wire awready, wready, bvalid, arready, rvalid, wake_pin, reset_pin_n, pwr_good, dig_wake_in;
  wire logic_power_en, io_supply_en, sram_retain, out_latch, boot_req, gnss_active;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [4:0] ret_blocks_64k;
  wire [7:0] pull_en, pull_up;
  integer n_mismatch = 0, cmp_count = 0, k;
  always #20 aclk = ~aclk;
  dspm_host_pins u_dspm_host_pins (.aclk(aclk), .go(go), .kind(kind), .wake_pin(wake_pin),
    .reset_pin_n(reset_pin_n), .pwr_good(pwr_good), .dig_wake_in(dig_wake_in));
  dspm_ctrl #(.TICK_CYC(TICK), .GUARD_SEC(GUARD)) u_dspm_ctrl (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .wake_pin(wake_pin),
    .reset_pin_n(reset_pin_n), .dig_wake_in(dig_wake_in), .pwr_good(pwr_good),
    .logic_power_en(logic_power_en), .io_supply_en(io_supply_en), .sram_retain(sram_retain),
    .ret_blocks_64k(ret_blocks_64k), .out_latch(out_latch), .pull_en(pull_en),
    .pull_up(pull_up), .boot_req(boot_req), .gnss_active(gnss_active));
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task wrap_up;
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task tmo;
    n_mismatch = n_mismatch + 1;
    wrap_up;
  endtask
  task chk(input [8*12-1:0] nm, input [31:0] seen, input [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("Error %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [31:0] dv, input [1:0] er);
    integer j;
    logic ha, hw, hb;
    logic [1:0] r;
    begin
      @(posedge aclk);
      awaddr <= a; wdata <= dv; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      hb = 1'b0;
      for (j = 0; j < 50 && !hb; j = j + 1) begin
        @(negedge aclk);
        ha = awready && awvalid; hw = wready && wvalid; hb = bvalid && bready; r = bresp;
        @(posedge aclk);
        if (ha) awvalid <= 1'b0;
        if (hw) wvalid <= 1'b0;
        if (hb) bready <= 1'b0;
      end
      if (!hb) tmo;
      chk("bresp", r, er);
    end
  endtask
  task rd(input [7:0] a, output [31:0] dv, output [1:0] r);
    integer j;
    logic ha, hr;
    begin
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      hr = 1'b0;
      for (j = 0; j < 50 && !hr; j = j + 1) begin
        @(negedge aclk);
        ha = arready && arvalid; hr = rvalid && rready; dv = rdata; r = rresp;
        @(posedge aclk);
        if (ha) arvalid <= 1'b0;
        if (hr) rready <= 1'b0;
      end
      if (!hr) tmo;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    rd(a, rv, r2);
    chk("rdata", rv, e);
    chk("rresp", r2, `DSPM_AXI_OKAY);
  endtask
  task nap(input [1:0] dp, input [31:0] sec, input [1:0] e, input [1:0] how);
    integer j;
    begin
      wr(`DSPM_CTRL_OFF, 32'h0000_0000, `DSPM_AXI_OKAY);
      wr(`DSPM_CFG_OFF, {23'h0, ret, 2'h0, dp}, `DSPM_AXI_OKAY);
      rdc(`DSPM_CFG_OFF, {23'h0, ret, 2'h0, dp});
      wr(`DSPM_SLEEP_OFF, sec, `DSPM_AXI_OKAY);
      wr(`DSPM_PIN_OFF, {16'h0, pin}, `DSPM_AXI_OKAY);
      wr(`DSPM_CTRL_OFF, 32'h0000_0001, `DSPM_AXI_OKAY);
      repeat (3) @(posedge aclk);
      chk("io_supply", io_supply_en, e == 2'h1);
      chk("sram_keep", sram_retain, e == 2'h1);
      chk("out_latch", out_latch, e == 2'h1);
      chk("ret_blocks", ret_blocks_64k, e == 2'h2 ? ret : 5'h00);
      chk("logic_pwr", logic_power_en, 1'b0);
      if (e == 2'h1) chk("pulls", {pull_en, pull_up}, {pin[7:0], pin[15:8]});
      else chk("pull_en", pull_en, 8'h00);
      // The wake line is asserted while the clock enable is low: nothing may move until it returns.
      go <= 1'b1;
      ce <= 1'b0;
      kind <= (e == 2'h1 && (how == 2'h0 || dp == 2'h0)) ? 2'h3 : how;
      repeat (6) @(negedge aclk);
      chk("ce_frozen", {boot_req, logic_power_en, io_supply_en}, {2'b00, e == 2'h1});
      @(posedge aclk);
      ce <= 1'b1;
      for (j = 0; j < 20 && boot_req !== 1'b1; j = j + 1) @(negedge aclk);
      if (j == 20) tmo;
      @(posedge aclk);
      go <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("logic_pwr", logic_power_en, 1'b1);
      if (e == 2'h3) chk("pull_def", {pull_en, pull_up}, 16'hffa5);
    end
  endtask
  initial begin
    repeat (100000) @(posedge aclk);
    tmo;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("pulls", {pull_en, pull_up}, 16'hffa5);
    rdc(`DSPM_CFG_OFF, 32'h0000_0011);
    rdc(`DSPM_CTRL_OFF, 32'h0000_0004);
    rdc(`DSPM_ELAPSED_OFF, 32'hffff_ffff);
    rd(8'h1c, rv, r2);
    chk("rresp", r2, `DSPM_AXI_SLVERR);
    wr(`DSPM_STAT_OFF, 32'h0000_0001, `DSPM_AXI_SLVERR);
    wr(`DSPM_GNSS_OFF, `DSPM_GNSS_START, `DSPM_AXI_OKAY);
    rdc(`DSPM_GNSS_OFF, 32'h0000_0004);
    wr(`DSPM_CTRL_OFF, 32'h0000_000c, `DSPM_AXI_OKAY);
    repeat (2) @(posedge aclk);
    chk("gnss_act", gnss_active, 1'b0);
    for (k = 1; k < 3; k = k + 1) begin
      wr(`DSPM_GNSS_OFF, k, `DSPM_AXI_OKAY);
      rdc(`DSPM_GNSS_OFF, 32'h0000_000a);
      chk("gnss_act", gnss_active, 1'b0);
    end
    wr(`DSPM_CTRL_OFF, 32'h0000_0004, `DSPM_AXI_OKAY);
    wr(`DSPM_GNSS_OFF, `DSPM_GNSS_START, `DSPM_AXI_OKAY);
    rdc(`DSPM_GNSS_OFF, 32'h0000_0004);
    wr(`DSPM_GNSS_OFF, `DSPM_GNSS_STOP, `DSPM_AXI_OKAY);
    rdc(`DSPM_GNSS_OFF, 32'h0000_0000);
    for (k = 0; k < 8; k = k + 1) begin
      rnd = lfsr(rnd);
      ret = rnd[4:0] == 5'h00 ? 5'h01 : rnd[4:0];
      pin = rnd[23:8];
      d = k[1:0];
      nap(d, d == 2'h3 ? {30'h0, rnd[26:25]} : rnd, d == 2'h0 ? 2'h1 : (d == 2'h3 ? 2'h2 : d),
        rnd[28:27] == 2'h3 ? 2'h0 : rnd[28:27]);
    end
    nap(2'h3, 32'd16, 2'h3, 2'h0);
    nap(2'h3, 32'd16, 2'h2, 2'h1);
    rd(`DSPM_STAT_OFF, rv, r2);
    chk("guard_sub", rv[10:9], 2'h3);
    repeat (GUARD * TICK + 60) @(posedge aclk);
    nap(2'h3, GUARD - 1, 2'h2, 2'h0);
    nap(2'h3, GUARD, 2'h3, 2'h0);
    wrap_up;
  end
endmodule // testbench
